// ### port_alternate_function_mux.sv
// alternate function multiplexer for ports a, b and c
`timescale 1ns/10ps
`default_nettype none
module port_alternate_function_mux
   import pin_mux_pkg::*;
(
   // clock and reset
   input  wire logic             core_clk_i,
   input  wire logic             reset_i,
   // configuration
   input  wire logic [1:0]       package_variant_i,
   input  wire logic             crystal_enable_i,
   input  wire logic             ext_osc_select_i,
   input  wire logic [7:0]       port_a_alt_enable_i,
   input  wire logic [7:0]       port_b_alt_enable_i,
   input  wire logic [7:0]       port_c_alt_enable_i,
   input  wire logic [7:0]       port_b_function_select_one_i,
   input  wire logic [7:0]       port_c_function_select_one_i,
   input  wire logic [7:0]       port_b_function_select_two_i,
   input  wire logic [7:0]       port_c_function_select_two_i,
   // timer mode: high when the shared pin acts as an input
   input  wire logic             timer_zero_in_mode_i,
   input  wire logic             timer_one_in_mode_i,
   // peripheral outputs and their direction requests
   input  wire logic             timer_zero_output_i,
   input  wire logic             timer_zero_compl_i,
   input  wire logic             timer_one_output_i,
   input  wire logic             timer_one_compl_i,
   input  wire logic             uart_driver_enable_i,
   input  wire logic             uart_transmit_i,
   input  wire logic             comparator_output_i,
   // gpio side
   input  wire logic [7:0]       gpio_a_out_i,
   input  wire logic [7:0]       gpio_a_oe_i,
   input  wire logic [7:0]       gpio_b_out_i,
   input  wire logic [7:0]       gpio_b_oe_i,
   input  wire logic [7:0]       gpio_c_out_i,
   input  wire logic [7:0]       gpio_c_oe_i,
   // pin levels
   input  wire logic [7:0]       pin_a_i,
   input  wire logic [7:0]       pin_b_i,
   // pin drive
   output logic      [7:0]       pin_a_o,
   output logic      [7:0]       pin_a_oe_o,
   output logic      [7:0]       pin_b_o,
   output logic      [7:0]       pin_b_oe_o,
   output logic      [7:0]       pin_c_o,
   output logic      [7:0]       pin_c_oe_o,
   // peripheral inputs
   output logic                  timer_zero_input_o,
   output logic                  timer_one_input_o,
   output logic                  uart_clear_to_send_o,
   output logic                  uart_receive_o,
   output logic                  ext_clock_in_o,
   output logic                  ext_clock_active_o,
   // analog and led switch enables
   output logic      [7:0]       port_b_analog_o,
   output logic                  port_b_vref_o,
   output logic      [7:0]       port_c_analog_o,
   output logic                  port_c_vref_o,
   output logic      [7:0]       port_c_led_o
);

   logic [7:0] a_alt;
   logic [7:0] b_one;
   logic [7:0] b_zero;
   logic [7:0] c_one;
   logic [7:0] c_zero;
   logic [7:0] a_per_out;
   logic [7:0] a_per_oe;
   logic [7:0] next_pin_a;
   logic [7:0] next_pin_a_oe;
   logic [7:0] next_pin_b_oe;
   logic [7:0] next_pin_c;
   logic [7:0] next_pin_c_oe;
   logic       small_pkg;

   // function select two is unused for ports b and c
   logic unused_fs2;
   assign unused_fs2 = ^{port_b_function_select_two_i,
                         port_c_function_select_two_i};

   assign small_pkg = (package_variant_i == PKG_8_PIN);

   // crystal takes pa0/pa1 away from gpio and alternate control
   always_comb begin
      a_alt = port_a_alt_enable_i;
      if (crystal_enable_i) begin
         a_alt[1:0] = 2'h0;
      end
   end

   port_bc_select #(.WIDTH(PORT_W)) u_sel_b (
      .alt_enable_i          (port_b_alt_enable_i),
      .function_select_one_i (port_b_function_select_one_i),
      .sel_one_o             (b_one),
      .sel_zero_o            (b_zero)
   );

   port_bc_select #(.WIDTH(PORT_W)) u_sel_c (
      .alt_enable_i          (port_c_alt_enable_i),
      .function_select_one_i (port_c_function_select_one_i),
      .sel_one_o             (c_one),
      .sel_zero_o            (c_zero)
   );

   // fixed port a peripheral drive; pa0/pa6 follow timer mode
   always_comb begin
      a_per_out = 8'h00;
      a_per_oe  = 8'h00;
      a_per_out[PA_TMR0_IO]  = timer_zero_compl_i;
      a_per_oe[PA_TMR0_IO]   = ~timer_zero_in_mode_i;
      a_per_out[PA_TMR0_OUT] = timer_zero_output_i;
      a_per_oe[PA_TMR0_OUT]  = ~small_pkg;
      a_per_out[PA_UART_DE]  = uart_driver_enable_i;
      a_per_oe[PA_UART_DE]   = 1'b1;
      a_per_out[PA_UART_TX]  = uart_transmit_i;
      a_per_oe[PA_UART_TX]   = 1'b1;
      a_per_out[PA_TMR1_IO]  = timer_one_compl_i;
      a_per_oe[PA_TMR1_IO]   = ~timer_one_in_mode_i;
      a_per_out[PA_TMR1_OUT] = timer_one_output_i;
      a_per_oe[PA_TMR1_OUT]  = 1'b1;
   end

   // pin drive: alternate mode hands direction to the peripheral on port a and pc3
   always_comb begin
      next_pin_a    = (gpio_a_out_i & ~a_alt) | (a_per_out & a_alt);
      next_pin_a_oe = (gpio_a_oe_i & ~a_alt) | (a_per_oe & a_alt);
      if (crystal_enable_i) begin
         next_pin_a[1:0]    = 2'h0;
         next_pin_a_oe[1:0] = 2'h0;
      end
      // port b alternate functions are inputs or analog only
      next_pin_b_oe = gpio_b_oe_i & ~(b_one & PB_ANALOG_MASK)
                      & ~b_zero_clock();
      next_pin_c    = gpio_c_out_i;
      next_pin_c_oe = gpio_c_oe_i & ~(c_one & PC_ANALOG_MASK);
      next_pin_c[PC_COMP_BIT] = c_zero[PC_COMP_BIT] ?
                                comparator_output_i :
                                gpio_c_out_i[PC_COMP_BIT];
      if (c_zero[PC_COMP_BIT]) begin
         next_pin_c_oe[PC_COMP_BIT] = 1'b1;
      end
   end

   // clock-in selection mask on pb3 (reserved bits stay gpio)
   function automatic logic [7:0] b_zero_clock();
      logic [7:0] m;
      m = 8'h00;
      m[PB_CLOCK_BIT] = b_zero[PB_CLOCK_BIT] & ~small_pkg;
      return m;
   endfunction

   // registered pin drive
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         pin_a_o    <= RESET_BYTE;
         pin_a_oe_o <= RESET_BYTE;
         pin_b_o    <= RESET_BYTE;
         pin_b_oe_o <= RESET_BYTE;
         pin_c_o    <= RESET_BYTE;
         pin_c_oe_o <= RESET_BYTE;
      end else begin
         pin_a_o    <= next_pin_a;
         pin_a_oe_o <= next_pin_a_oe;
         pin_b_o    <= gpio_b_out_i;
         pin_b_oe_o <= next_pin_b_oe;
         pin_c_o    <= next_pin_c;
         pin_c_oe_o <= next_pin_c_oe;
      end
   end

   // registered peripheral inputs; uart receive idles high, clear to send idles low
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         timer_zero_input_o   <= 1'b0;
         timer_one_input_o    <= 1'b0;
         uart_clear_to_send_o <= 1'b0;
         uart_receive_o       <= 1'b1;
      end else begin
         timer_zero_input_o   <= a_alt[PA_TMR0_IO] & timer_zero_in_mode_i
                                 & pin_a_i[PA_TMR0_IO];
         timer_one_input_o    <= a_alt[PA_TMR1_IO] & timer_one_in_mode_i
                                 & pin_a_i[PA_TMR1_IO];
         uart_clear_to_send_o <= a_alt[PA_UART_CTS] &
                                 pin_a_i[PA_UART_CTS];
         uart_receive_o       <= ~a_alt[PA_UART_RX] |
                                 pin_a_i[PA_UART_RX];
      end
   end

   // external clock source: pb3 on larger parts, pa1 on 8-pin parts
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         ext_clock_active_o <= 1'b0;
         ext_clock_in_o     <= 1'b0;
      end else if (small_pkg) begin
         ext_clock_active_o <= a_alt[PA_TMR0_OUT] & ext_osc_select_i;
         ext_clock_in_o     <= a_alt[PA_TMR0_OUT] & ext_osc_select_i
                               & pin_a_i[PA_TMR0_OUT];
      end else begin
         ext_clock_active_o <= b_zero[PB_CLOCK_BIT] & ext_osc_select_i;
         ext_clock_in_o     <= b_zero[PB_CLOCK_BIT] & ext_osc_select_i
                               & pin_b_i[PB_CLOCK_BIT];
      end
   end

   // analog switch and led enables
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         port_b_analog_o <= RESET_BYTE;
         port_b_vref_o   <= 1'b0;
         port_c_analog_o <= RESET_BYTE;
         port_c_vref_o   <= 1'b0;
         port_c_led_o    <= RESET_BYTE;
      end else begin
         port_b_analog_o <= b_one & PB_ANALOG_MASK & ~8'h20;
         port_b_vref_o   <= b_one[PB_VREF_BIT] &
                            (package_variant_i == PKG_28_PIN);
         port_c_analog_o <= c_one & PC_ANALOG_MASK;
         port_c_vref_o   <= c_one[PC_VREF_BIT] &
                            (package_variant_i == PKG_20_PIN);
         port_c_led_o    <= c_one;
      end
   end

   // checks
   pb_vref_pkg_a: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      port_b_vref_o |-> $past(package_variant_i) == PKG_28_PIN)
      else $error("pb5 reference outside 28-pin part");
   pc_vref_pkg_a: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      port_c_vref_o |-> $past(package_variant_i) == PKG_20_PIN)
      else $error("pc2 reference outside 20-pin part");
   led_follow_a: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      ##1 port_c_led_o == $past(port_c_alt_enable_i
                                & port_c_function_select_one_i))
      else $error("led enable does not follow select");
   xtal_release_a: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      crystal_enable_i |=> pin_a_oe_o[1:0] == 2'h0)
      else $error("crystal pins still driven");
   clk_b_a: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      ext_clock_active_o && $past(package_variant_i) != PKG_8_PIN
      |-> $past(port_b_alt_enable_i[PB_CLOCK_BIT]
                & ~port_b_function_select_one_i[PB_CLOCK_BIT]))
      else $error("clock active without pb3 select");
   pb_high_a: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      port_b_analog_o[7:5] == 3'h0)
      else $error("pb6/pb7 got an analog function");
   comp_drive_a: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      c_zero[PC_COMP_BIT] |=> pin_c_oe_o[PC_COMP_BIT]
                              && pin_c_o[PC_COMP_BIT] ==
                                 $past(comparator_output_i))
      else $error("comparator output not driven");
   a_dir_a: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      a_alt[PA_UART_DE] |=> pin_a_oe_o[PA_UART_DE])
      else $error("driver enable pin not driven");
   cov_clk_c: cover property (@(posedge core_clk_i) ext_clock_active_o);
   cov_led_c: cover property (@(posedge core_clk_i) port_c_led_o == 8'hFF);
   cov_xtal_c: cover property (@(posedge core_clk_i) crystal_enable_i);

endmodule
`default_nettype wire

// ### pin_mux_pkg.sv
// package: constants for the port alternate function multiplexer
package pin_mux_pkg;
   localparam int PORT_W = 8;
   // package variants
   localparam logic [1:0] PKG_8_PIN  = 2'h0;
   localparam logic [1:0] PKG_20_PIN = 2'h1;
   localparam logic [1:0] PKG_28_PIN = 2'h2;
   // port a fixed function bit positions
   localparam int PA_TMR0_IO  = 0;
   localparam int PA_TMR0_OUT = 1;
   localparam int PA_UART_DE  = 2;
   localparam int PA_UART_CTS = 3;
   localparam int PA_UART_RX  = 4;
   localparam int PA_UART_TX  = 5;
   localparam int PA_TMR1_IO  = 6;
   localparam int PA_TMR1_OUT = 7;
   // port b / c bit positions
   localparam int PB_CLOCK_BIT = 3;
   localparam int PB_VREF_BIT  = 5;
   localparam int PC_VREF_BIT  = 2;
   localparam int PC_COMP_BIT  = 3;
   // port b analog select map: bits 0..5 have analog use
   localparam logic [7:0] PB_ANALOG_MASK = 8'h3F;
   // port c analog select map: bits 0..2
   localparam logic [7:0] PC_ANALOG_MASK = 8'h07;
   // reset value of the eight-bit registered outputs
   localparam logic [7:0] RESET_BYTE = 8'h00;
endpackage

// ### port_bc_select.sv
// two-choice select decoder for port b or port c
`timescale 1ns/10ps
`default_nettype none
module port_bc_select
   import pin_mux_pkg::*;
#(
   parameter int WIDTH = 8
) (
   // configuration
   input  wire logic [WIDTH-1:0] alt_enable_i,
   input  wire logic [WIDTH-1:0] function_select_one_i,
   // decoded choices
   output logic      [WIDTH-1:0] sel_one_o,
   output logic      [WIDTH-1:0] sel_zero_o
);
   // a select bit matters only while the pin is in alternate mode
   assign sel_one_o  = alt_enable_i & function_select_one_i;
   assign sel_zero_o = alt_enable_i & ~function_select_one_i;
endmodule
`default_nettype wire

// ### peripheral_model.sv
// behavioural model of the timers, uart and comparator beside the mux
`timescale 1ns/10ps
`default_nettype none
module peripheral_model (
   // clock and reset
   input  wire logic core_clk_i,
   input  wire logic reset_i,
   // peripheral levels towards the mux
   output logic      timer_zero_output_o,
   output logic      timer_zero_compl_o,
   output logic      timer_one_output_o,
   output logic      timer_one_compl_o,
   output logic      uart_driver_enable_o,
   output logic      uart_transmit_o,
   output logic      comparator_output_o
);
   logic [6:0] phase;
   // levels move at each falling edge, so a stale route shows up at once
   always_ff @(negedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         phase <= 7'h55;
      end else begin
         phase <= phase + 7'h13;
      end
   end
   // each peripheral output is one bit of the moving phase
   assign timer_zero_output_o  = phase[0];
   assign timer_zero_compl_o   = phase[1];
   assign timer_one_output_o   = phase[2];
   assign timer_one_compl_o    = phase[3];
   assign uart_driver_enable_o = phase[4];
   assign uart_transmit_o      = phase[5];
   assign comparator_output_o  = phase[6];
endmodule
`default_nettype wire

// ### test_port_alternate_function_mux.sv
// testbench for the port alternate function multiplexer
`timescale 1ns/10ps
`default_nettype none
module test_port_alternate_function_mux;
   import pin_mux_pkg::*;
   logic       core_clk_i, reset_i, xtal, ext_osc, t0_in, t1_in;
   logic [1:0] variant;
   logic [7:0] a_alt, b_alt, c_alt, b_fs1, c_fs1, b_fs2, c_fs2;
   logic [7:0] ga_out, ga_oe, gb_out, gb_oe, gc_out, gc_oe, pa, pb;
   logic [7:0] pa_o, pa_oe, pb_o, pb_oe, pc_o, pc_oe, b_an, c_an, c_led;
   logic       t0_o, t1_o, cts, rx, clk_in, clk_act, b_vref, c_vref;
   logic       t0_out, t0_cmp, t1_out, t1_cmp, de, tx, cmp_o;
   int         miscompares, samples_checked;
   peripheral_model periph (.core_clk_i(core_clk_i), .reset_i(reset_i),
      .timer_zero_output_o(t0_out), .timer_zero_compl_o(t0_cmp),
      .timer_one_output_o(t1_out), .timer_one_compl_o(t1_cmp),
      .uart_driver_enable_o(de), .uart_transmit_o(tx),
      .comparator_output_o(cmp_o));
   port_alternate_function_mux uut (.core_clk_i(core_clk_i),
      .reset_i(reset_i), .package_variant_i(variant),
      .crystal_enable_i(xtal), .ext_osc_select_i(ext_osc),
      .port_a_alt_enable_i(a_alt), .port_b_alt_enable_i(b_alt),
      .port_c_alt_enable_i(c_alt), .port_b_function_select_one_i(b_fs1),
      .port_c_function_select_one_i(c_fs1),
      .port_b_function_select_two_i(b_fs2),
      .port_c_function_select_two_i(c_fs2),
      .timer_zero_in_mode_i(t0_in), .timer_one_in_mode_i(t1_in),
      .timer_zero_output_i(t0_out), .timer_zero_compl_i(t0_cmp),
      .timer_one_output_i(t1_out), .timer_one_compl_i(t1_cmp),
      .uart_driver_enable_i(de), .uart_transmit_i(tx),
      .comparator_output_i(cmp_o), .gpio_a_out_i(ga_out),
      .gpio_a_oe_i(ga_oe), .gpio_b_out_i(gb_out), .gpio_b_oe_i(gb_oe),
      .gpio_c_out_i(gc_out), .gpio_c_oe_i(gc_oe), .pin_a_i(pa),
      .pin_b_i(pb), .pin_a_o(pa_o), .pin_a_oe_o(pa_oe), .pin_b_o(pb_o),
      .pin_b_oe_o(pb_oe), .pin_c_o(pc_o), .pin_c_oe_o(pc_oe),
      .timer_zero_input_o(t0_o), .timer_one_input_o(t1_o),
      .uart_clear_to_send_o(cts), .uart_receive_o(rx),
      .ext_clock_in_o(clk_in), .ext_clock_active_o(clk_act),
      .port_b_analog_o(b_an), .port_b_vref_o(b_vref),
      .port_c_analog_o(c_an), .port_c_vref_o(c_vref), .port_c_led_o(c_led));
   // compares one result and counts it
   task automatic chk(input string what, input logic [7:0] exp, got);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // lets the sampling edge land before looking at registered outputs
   task automatic settle();
      @(posedge core_clk_i);
      #1;
   endtask
   // prints the counts and the verdict, then stops
   task automatic end_sim();
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // free-running system clock
   initial begin
      core_clk_i = 1'b0;
      forever #10 core_clk_i = ~core_clk_i;
   end
   // watchdog far beyond the few dozen cycles the tests need
   initial begin
      #100000;
      miscompares++;
      end_sim();
   end
   // main sequence
   initial begin
      miscompares = 0; samples_checked = 0; reset_i = 1'b1;
      variant = PKG_28_PIN; xtal = 1'b0; ext_osc = 1'b0;
      t0_in = 1'b0; t1_in = 1'b0; a_alt = 8'h00; b_alt = 8'h00;
      c_alt = 8'h00; b_fs1 = 8'h00; c_fs1 = 8'h00; b_fs2 = 8'h00;
      c_fs2 = 8'hFF; ga_out = 8'h00; ga_oe = 8'h00; gb_out = 8'h00;
      gb_oe = 8'h00; gc_out = 8'h00; gc_oe = 8'h00; pa = 8'h00; pb = 8'h00;
      repeat (4) @(posedge core_clk_i);
      chk("reset pin_a_oe", 8'h00, pa_oe);
      chk("reset pin_c_oe", 8'h00, pc_oe);
      chk("reset led", 8'h00, c_led);
      chk("reset receive", 8'h01, {7'h00, rx});
      @(negedge core_clk_i);
      reset_i = 1'b0; ga_out = 8'hA5; ga_oe = 8'h3C;
      settle();
      chk("gpio a out", 8'hA5, pa_o);
      chk("gpio a oe", 8'h3C, pa_oe);
      $display("test port a gpio done");
      @(negedge core_clk_i);
      a_alt = 8'hFF; ga_oe = 8'h00; pa = 8'h08;
      settle();
      chk("alt a oe", 8'hE7, pa_oe);
      chk("alt a out", {t1_out, t1_cmp, tx, 2'b00, de, t0_out, t0_cmp},
          pa_o & 8'hE7);
      chk("cts", 8'h01, {7'h00, cts});
      chk("receive", 8'h00, {7'h00, rx});
      @(negedge core_clk_i);
      ga_oe = 8'hFF; t0_in = 1'b1; t1_in = 1'b1; pa = 8'h51;
      settle();
      chk("alt a oe input", 8'hA6, pa_oe);
      chk("timer inputs", 8'h03, {6'h00, t1_o, t0_o});
      chk("cts receive", 8'h01, {6'h00, cts, rx});
      @(negedge core_clk_i);
      xtal = 1'b1;
      settle();
      chk("crystal oe", 8'h00, pa_oe & 8'h03);
      chk("crystal out", 8'h00, pa_o & 8'h03);
      chk("crystal timer in", 8'h00, {7'h00, t0_o});
      $display("test port a alternate done");
      @(negedge core_clk_i);
      xtal = 1'b0; b_alt = 8'hFF; b_fs1 = 8'hFF; gb_out = 8'h5A;
      gb_oe = 8'hFF;
      settle();
      chk("b analog", 8'h1F, b_an);
      chk("b vref 28", 8'h01, {7'h00, b_vref});
      chk("b reserved oe", 8'hC0, pb_oe & 8'hC0);
      chk("b reserved out", 8'h40, pb_o & 8'hC0);
      @(negedge core_clk_i);
      b_fs2 = 8'hFF; variant = PKG_20_PIN;
      settle();
      chk("b analog fs2", 8'h1F, b_an);
      chk("b vref 20", 8'h00, {7'h00, b_vref});
      @(negedge core_clk_i);
      b_fs1 = 8'h00; ext_osc = 1'b1; pb = 8'h08;
      settle();
      chk("b analog off", 8'h00, b_an);
      chk("clock high", 8'h03, {6'h00, clk_act, clk_in});
      chk("b gpio oe", 8'hF7, pb_oe & 8'hF7);
      chk("pb3 oe", 8'h00, pb_oe & 8'h08);
      @(negedge core_clk_i);
      pb = 8'h00;
      settle();
      chk("clock low", 8'h00, {7'h00, clk_in});
      @(negedge core_clk_i);
      b_alt = 8'h00; b_fs1 = 8'hFF; variant = PKG_28_PIN;
      settle();
      chk("b no alt", 8'h00, b_an);
      chk("b no alt vref", 8'h00, {7'h00, b_vref});
      $display("test port b done");
      @(negedge core_clk_i);
      variant = PKG_8_PIN; b_alt = 8'h08; b_fs1 = 8'h00; a_alt = 8'h02;
      pa = 8'h02;
      settle();
      chk("clock pa1", 8'h03, {6'h00, clk_act, clk_in});
      chk("pa1 oe", 8'h00, pa_oe & 8'h02);
      @(negedge core_clk_i);
      pa = 8'h00; pb = 8'h08;
      settle();
      chk("clock not pb3", 8'h00, {7'h00, clk_in});
      $display("test small package clock done");
      @(negedge core_clk_i);
      variant = PKG_20_PIN; c_alt = 8'hFF; c_fs1 = 8'hFF; gc_oe = 8'hFF;
      gc_out = 8'h3C;
      settle();
      chk("c led", 8'hFF, c_led);
      chk("c analog", 8'h07, c_an);
      chk("c vref 20", 8'h01, {7'h00, c_vref});
      chk("c oe", 8'hF8, pc_oe);
      @(negedge core_clk_i);
      variant = PKG_28_PIN; c_fs2 = 8'h00;
      settle();
      chk("c vref 28", 8'h00, {7'h00, c_vref});
      chk("c led fs2", 8'hFF, c_led);
      @(negedge core_clk_i);
      c_fs1 = 8'h00;
      settle();
      chk("c comparator", {4'h0, cmp_o, 3'h0}, pc_o & 8'h08);
      chk("c comparator oe", 8'h08, pc_oe & 8'h08);
      chk("c led off", 8'h00, c_led);
      chk("c gpio oe", 8'hF7, pc_oe & 8'hF7);
      chk("c gpio out", 8'h34, pc_o & 8'hF7);
      $display("test port c done");
      end_sim();
   end
endmodule
`default_nettype wire
